// ### dv/bdos_clk_src.sv
// External output clock source, one rising edge per request
module bdos_clk_src (
  input  wire logic clk,      // System clock
  input  wire logic arst_n,   // Async reset, active low
  input  wire logic tick_req, // Request one clock edge
  output logic      ext_clk   // External output clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hi_cnt;

  // Stands still between requests, so no stray ticks reach the block
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt <= 2'h0;
    end else if (tick_req) begin
      hi_cnt <= 2'h2;
    end else if (hi_cnt != 2'h0) begin
      hi_cnt <= hi_cnt - 2'h1;
    end
  end
  assign ext_clk = (hi_cnt != 2'h0);
endmodule : bdos_clk_src

// ### dv/bdos_properties.sv
// Concurrent checks on the sequencer's ports
module bdos_properties
  import bdos_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic                   clk,           // System clock
  input wire logic                   arst_n,        // Async reset
  input wire logic [ADDR_W-1:0]      s_axi_awaddr,  // Write address
  input wire logic                   s_axi_awvalid, // Write addr valid
  input wire logic                   s_axi_awready, // Write addr ready
  input wire logic                   s_axi_wvalid,  // Write data valid
  input wire logic                   s_axi_wready,  // Write data ready
  input wire logic [1:0]             s_axi_bresp,   // Write response
  input wire logic                   s_axi_bvalid,  // Write resp valid
  input wire logic                   s_axi_bready,  // Write resp ready
  input wire logic [ADDR_W-1:0]      s_axi_araddr,  // Read address
  input wire logic                   s_axi_arvalid, // Read addr valid
  input wire logic                   s_axi_arready, // Read addr ready
  input wire logic [DATA_W-1:0]      s_axi_rdata,   // Read data
  input wire logic [1:0]             s_axi_rresp,   // Read response
  input wire logic                   s_axi_rvalid,  // Read data valid
  input wire logic                   s_axi_rready,  // Read data ready
  input wire logic [NCH-1:0][VAL_W-1:0] dac_value, // Output codes
  input wire logic [NCH-1:0]         dac_load       // Update pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  load_pulse_a: assert property (dac_load != '0 |=> dac_load == '0)
    else $error("update pulse longer than one cycle");
  value_hold_a: assert property ($changed(dac_value) |-> dac_load != '0)
    else $error("output code changed without update pulse");
  // Buffer writes may stall on a full store, so every other address is bounded
  wr_resp_a: assert property (wr_both_s ##0 (s_axi_awaddr != OFS_OUT_DATA)
    |=> ##[0:3] s_axi_bvalid) else $error("write response missing");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  rd_resp_a: assert property (rd_take_s |=> s_axi_rvalid)
    else $error("read data late");
  unmap_rd_a: assert property (rd_take_s ##0 (s_axi_araddr >= 8'h18)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");
endmodule : bdos_properties

bind bdos_top bdos_properties #(.NCH(NCH)) u_props (
  .clk(clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .dac_value(dac_value), .dac_load(dac_load));

// ### dv/bdos_top_tb.sv
// Self-checking bench for the buffered output sequencer
module bdos_top_tb
  import bdos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, tick_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ext_clk;
  logic [1:0] bresp, rresp, bresp_seen;
  logic [31:0] rdata;
  logic [NCH-1:0][15:0] dac_value;
  logic [NCH-1:0] dac_load, last_mask;
  int err_count = 0, n_tests = 0, n_loads = 0;
  int cyc = 0, t_prev = 0, t_last = 0;

  bdos_top #(.NCH(NCH), .DEPTH(64)) uut (
    .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_out_clk(ext_clk), .dac_value(dac_value),
    .dac_load(dac_load));
  bdos_clk_src u_src (.clk(clk), .arst_n(arst_n), .tick_req(tick_req),
    .ext_clk(ext_clk));

  always #2.5 clk = ~clk;

  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dac_load != '0) begin
      last_mask <= dac_load;
      n_loads <= n_loads + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Ready is looked at mid-cycle, i.e. as the next rising edge sees it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    b_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      bresp_seen = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar_ok, ok;
    ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok) begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
      if (ok) rready <= 1'b0;
    end
  endtask : rd

  task tick;
    @(posedge clk);
    tick_req <= 1'b1;
    @(posedge clk);
    tick_req <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : tick

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_BOARD_CTRL, d, r);
    chk(d, 32'h0);
    rd(OFS_BUF_OPS, d, r);
    chk(d, 32'h100);
    rd(OFS_CH_GROUP, d, r);
    chk(d, 32'hf);
    rd(OFS_RATE_DIV, d, r);
    chk(d, 32'(DIV_DEFAULT));
    rd(8'h18, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(8'h18, 32'h0);
    chk(32'(bresp_seen), 32'(RESP_SLVERR));
    wr(OFS_CH_GROUP, 32'hf);
    chk(32'(bresp_seen), 32'(RESP_OKAY));
  endtask : t_reset

  // Values queue up while clocking is off, then drain one per tick
  task automatic t_seq;
    for (int i = 0; i < 5; i++) wr(OFS_OUT_DATA, 32'ha5a51000 + i);
    tick();
    chk(n_loads, 0);
    wr(OFS_BUF_OPS, 32'h2);
    for (int i = 0; i < 5; i++) begin
      tick();
      chk(last_mask, 4'h1 << (i % 4));
      chk(dac_value[i % 4], 16'h1000 + i);
    end
    tick();
    chk(n_loads, 5);
  endtask : t_seq

  task automatic t_one;
    wr(OFS_CH_GROUP, 32'h4);
    wr(OFS_BOARD_CTRL, 32'h4);
    wr(OFS_OUT_DATA, 32'h0123);
    tick();
    chk(last_mask, 4'h4);
    chk(dac_value[2], 16'h8123);
    wr(OFS_BOARD_CTRL, 32'h0);
  endtask : t_one

  task automatic t_simul;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(OFS_BOARD_CTRL, 32'h1);
    wr(OFS_CH_GROUP, 32'hf);
    wr(OFS_BUF_OPS, 32'h6);
    n = n_loads;
    for (int i = 0; i < 3; i++) wr(OFS_OUT_DATA, 32'h2000 + i);
    tick();
    chk(n_loads, n);
    rd(OFS_STATUS, d, r);
    chk(d, 32'h3);
    wr(OFS_OUT_DATA, 32'h2003);
    repeat (10) @(posedge clk);
    tick();
    chk(last_mask, 4'hf);
    chk(n_loads, n + 1);
    for (int i = 0; i < 4; i++) chk(dac_value[i], 16'h2000 + i);
  endtask : t_simul

  task automatic t_clear;
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_BUF_OPS, 32'h0);
    wr(OFS_BOARD_CTRL, 32'h0);
    wr(OFS_OUT_DATA, 32'h1);
    wr(OFS_OUT_DATA, 32'h2);
    rd(OFS_BUF_OPS, d, r);
    chk(d, 32'h0);
    wr(OFS_BUF_OPS, 32'h4);
    rd(OFS_BUF_OPS, d, r);
    chk(d, 32'h100);
  endtask : t_clear

  // Generator must stay silent until its own enable is set as well
  task automatic t_int;
    logic [31:0] d;
    logic [1:0] r;
    int n, k;
    wr(OFS_RATE_DIV, 32'd100);
    rd(OFS_RATE_DIV, d, r);
    chk(d, 32'd200);
    for (int i = 0; i < 3; i++) wr(OFS_OUT_DATA, 32'h3000 + i);
    wr(OFS_BUF_OPS, 32'h3);
    n = n_loads;
    repeat (600) @(posedge clk);
    chk(n_loads, n);
    wr(OFS_BOARD_CTRL, 32'h2);
    k = 0;
    while (n_loads < n + 3 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk(n_loads, n + 3);
    chk(t_last - t_prev, 200);
    wr(OFS_BUF_OPS, 32'h0);
  endtask : t_int

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_seq();
    t_one();
    t_simul();
    t_clear();
    t_int();
    summarize();
  end
endmodule : bdos_top_tb

// ### inc/bdos_pkg.sv
// Register map, field positions, reset values and timing for the sequencer
package bdos_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W  = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_BOARD_CTRL = 8'h00;
  localparam logic [7:0] OFS_BUF_OPS    = 8'h04;
  localparam logic [7:0] OFS_CH_GROUP   = 8'h08;
  localparam logic [7:0] OFS_RATE_DIV   = 8'h0c;
  localparam logic [7:0] OFS_OUT_DATA   = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;

  // board_control_reg fields
  localparam int BCR_SIMUL_BIT   = 0;
  localparam int BCR_RATE_EN_BIT = 1;
  localparam int BCR_TWOS_BIT    = 2;

  // Buffer operations register fields
  localparam int BOPS_CLK_INT_BIT = 0;
  localparam int BOPS_CLK_EN_BIT  = 1;
  localparam int BOPS_CLEAR_BIT   = 2;
  localparam int BOPS_EMPTY_BIT   = 8;

  // Values after reset
  localparam logic RST_SIMUL   = 1'b0;
  localparam logic RST_RATE_EN = 1'b0;
  localparam logic RST_TWOS    = 1'b0;
  localparam logic RST_CLK_INT = 1'b0;
  localparam logic RST_CLK_EN  = 1'b0;

  // Output rate timing
  localparam int CLK_HZ           = 200_000_000;
  localparam int RATE_DEFAULT_SPS = 320_000;
  localparam int RATE_MAX_SPS     = 1_000_000;
  localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / RATE_DEFAULT_SPS);
  localparam logic [15:0] DIV_MIN     = 16'(CLK_HZ / RATE_MAX_SPS);

  localparam logic [VAL_W-1:0] SIGN_FLIP = 16'h8000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BDOS_IDLE,
    BDOS_GATHER,
    BDOS_ARMED
  } bdos_state_e;

endpackage : bdos_pkg

// ### rtl/bdos_fifo.sv
// Output value buffer: first-in first-out store in flip-flops
module bdos_fifo
  import bdos_pkg::*;
#(
  parameter int DW    = 16,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,        // System clock
  input  wire logic          arst_n,     // Async reset, active low
  input  wire logic          clear,      // Discard all entries
  input  wire logic          push_valid, // Write request
  output logic               push_ready, // Room for a write
  input  wire logic [DW-1:0] push_data,  // Write data
  output logic               pop_valid,  // Entry available
  input  wire logic          pop_ready,  // Consume head entry
  output logic [DW-1:0]      pop_data,   // Head entry
  output logic [AW:0]        level       // Entries held
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [AW-1:0]            wp;
    logic [AW-1:0]            rp;
    logic [AW:0]              cnt;
  } bdos_fifo_s;

  bdos_fifo_s s_reg;
  bdos_fifo_s s_next;

  logic do_push;
  logic do_pop;

  assign push_ready = (s_reg.cnt != (AW+1)'(DEPTH));
  assign pop_valid  = (s_reg.cnt != '0);
  assign pop_data   = s_reg.mem[s_reg.rp];
  assign level      = s_reg.cnt;
  assign do_push    = push_valid && push_ready;
  assign do_pop     = pop_ready && pop_valid;

  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.wp  = '0;
      s_next.rp  = '0;
      s_next.cnt = '0;
    end else begin
      if (do_push) begin
        s_next.mem[s_reg.wp] = push_data;
        s_next.wp = (s_reg.wp == AW'(DEPTH-1)) ? '0 : s_reg.wp + 1'b1;
      end
      if (do_pop) begin
        s_next.rp = (s_reg.rp == AW'(DEPTH-1)) ? '0 : s_reg.rp + 1'b1;
      end
      s_next.cnt = s_reg.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : bdos_fifo

// ### rtl/bdos_top.sv
// Buffered analog output sequencer with AXI4-Lite register access
//
// Overview of operation
// - After reset every output channel is active
// - After reset output words use offset binary
// - Reset: open empty buffer, sequential, 320KSPS rate
// - Reset clock source selects the external clock
// - Reset leaves output clocking disabled
// - Source bit high selects internal rate generator
// - Internal clock needs clocking and generator enabled
// - Clear bit write empties the output buffer
// - Sequential: each value updates its channel per tick
// - Sequential: ascending active channels, wrapping around
// - Open mode ignores end-of-frame markers
// - Only low sixteen data bits carry the value
// - Fast writes wait in buffer, never dropped
// - Simultaneous bit selects update mode
// - Simultaneous: partial group held, no output change
// - Simultaneous: full group updates all at one tick
// - Sequential per-channel rate is clock over count
// - Transfer only with data and clock present
module bdos_top
  import bdos_pkg::*;
#(
  parameter int NCH   = 4,
  parameter int DEPTH = 64
) (
  input  wire logic              clk,           // System clock, 200 MHz
  input  wire logic              arst_n,        // Async reset, active low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  input  wire logic [DATA_W-1:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Write byte enables
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  output logic [DATA_W-1:0]      s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready,  // Read data ready
  input  wire logic              ext_out_clk,   // External output clock
  output logic [NCH-1:0][VAL_W-1:0] dac_value,  // Per-channel output code
  output logic [NCH-1:0]         dac_load       // Channel update pulse
);

  localparam int CH_W  = $clog2(NCH);
  localparam int CNT_W = $clog2(NCH + 1);
  localparam int LVL_W = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic                        awready;
    logic                        wready;
    logic                        aw_hold;
    logic                        w_hold;
    logic [ADDR_W-1:0]           awaddr;
    logic [DATA_W-1:0]           wdata;
    logic [3:0]                  wstrb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [DATA_W-1:0]           rdata;
    logic [1:0]                  rresp;
    logic                        simul;
    logic                        rate_en;
    logic                        twos;
    logic                        clk_int;
    logic                        clk_en;
    logic [NCH-1:0]              mask;
    logic [15:0]                 div;
    logic [15:0]                 rate_cnt;
    logic                        ext_q;
    bdos_state_e                 state;
    logic [CH_W-1:0]             ptr;
    logic [CNT_W-1:0]            left;
    logic [NCH-1:0][VAL_W-1:0]   stage;
    logic [NCH-1:0][VAL_W-1:0]   dac;
    logic [NCH-1:0]              load;
  } bdos_s;

  bdos_s s_reg;
  bdos_s s_next;

  logic              fifo_clear;
  logic              push_valid;
  logic              push_ready;
  logic [VAL_W-1:0]  push_data;
  logic              pop_valid;
  logic              pop_ready;
  logic [VAL_W-1:0]  pop_data;
  logic [LVL_W-1:0]  level;

  // Next active channel above ptr, wrapping; ptr itself is tried last
  function automatic logic [CH_W-1:0] next_act(
    input logic [CH_W-1:0] ptr,
    input logic [NCH-1:0]  mask
  );
    logic [CH_W-1:0] res;
    logic            found;
    int              idx;
    res   = ptr;
    found = 1'b0;
    for (int i = 1; i <= NCH; i++) begin
      idx = (int'(ptr) + i) % NCH;
      if (!found && mask[idx]) begin
        res   = CH_W'(idx);
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_act

  function automatic logic [CNT_W-1:0] count_act(input logic [NCH-1:0] m);
    logic [CNT_W-1:0] c;
    c = '0;
    for (int i = 0; i < NCH; i++) begin
      c = c + CNT_W'(m[i]);
    end
    return c;
  endfunction : count_act

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [3:0]        st
  );
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    logic              tick;
    logic              rate_tick;
    logic              wr_go;
    logic              data_wr;
    logic              mapped;
    logic [DATA_W-1:0] cur;
    logic [DATA_W-1:0] nv;
    logic [CH_W-1:0]   ch;
    logic [CNT_W-1:0]  n_act;
    logic [VAL_W-1:0]  code;
    tick      = 1'b0;
    rate_tick = 1'b0;
    wr_go     = 1'b0;
    data_wr   = 1'b0;
    mapped    = 1'b0;
    cur       = '0;
    nv        = '0;
    ch        = '0;
    n_act     = count_act(s_reg.mask);
    code      = s_reg.twos ? (pop_data ^ SIGN_FLIP) : pop_data;
    s_next    = s_reg;
    s_next.load = '0;
    fifo_clear  = 1'b0;
    push_valid  = 1'b0;
    pop_ready   = 1'b0;
    // Only the low half of a data word is kept; bit 16 and above,
    // including any end-of-frame marker, are dropped here
    push_data   = s_reg.wdata[VAL_W-1:0];

    // Write address and data are taken independently
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_hold = 1'b1;
      s_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_hold = 1'b1;
      s_next.wdata  = s_axi_wdata;
      s_next.wstrb  = s_axi_wstrb;
    end

    // Perform a held write; a data write waits while the buffer is full
    if (s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid) begin
      data_wr = (s_reg.awaddr == OFS_OUT_DATA);
      wr_go   = !data_wr || push_ready;
    end
    if (wr_go) begin
      mapped = 1'b1;
      unique case (s_reg.awaddr)
        OFS_BOARD_CTRL: begin
          cur = '0;
          cur[BCR_SIMUL_BIT]   = s_reg.simul;
          cur[BCR_RATE_EN_BIT] = s_reg.rate_en;
          cur[BCR_TWOS_BIT]    = s_reg.twos;
          nv  = merge(cur, s_reg.wdata, s_reg.wstrb);
          s_next.simul   = nv[BCR_SIMUL_BIT];
          s_next.rate_en = nv[BCR_RATE_EN_BIT];
          s_next.twos    = nv[BCR_TWOS_BIT];
        end
        OFS_BUF_OPS: begin
          cur = '0;
          cur[BOPS_CLK_INT_BIT] = s_reg.clk_int;
          cur[BOPS_CLK_EN_BIT]  = s_reg.clk_en;
          nv  = merge(cur, s_reg.wdata, s_reg.wstrb);
          s_next.clk_int = nv[BOPS_CLK_INT_BIT];
          s_next.clk_en  = nv[BOPS_CLK_EN_BIT];
          fifo_clear     = nv[BOPS_CLEAR_BIT];
        end
        OFS_CH_GROUP: begin
          cur = DATA_W'(s_reg.mask);
          nv  = merge(cur, s_reg.wdata, s_reg.wstrb);
          s_next.mask = nv[NCH-1:0];
        end
        OFS_RATE_DIV: begin
          cur = DATA_W'(s_reg.div);
          nv  = merge(cur, s_reg.wdata, s_reg.wstrb);
          // Faster than the converter limit is clamped, not refused
          s_next.div = (nv[15:0] < DIV_MIN) ? DIV_MIN : nv[15:0];
        end
        OFS_OUT_DATA: begin
          push_valid = 1'b1;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
      s_next.aw_hold = 1'b0;
      s_next.w_hold  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    s_next.awready = !s_next.aw_hold && !s_next.bvalid;
    s_next.wready  = !s_next.w_hold && !s_next.bvalid;

    // Read channel
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = '0;
      unique case (s_axi_araddr)
        OFS_BOARD_CTRL: begin
          s_next.rdata[BCR_SIMUL_BIT]   = s_reg.simul;
          s_next.rdata[BCR_RATE_EN_BIT] = s_reg.rate_en;
          s_next.rdata[BCR_TWOS_BIT]    = s_reg.twos;
        end
        OFS_BUF_OPS: begin
          s_next.rdata[BOPS_CLK_INT_BIT] = s_reg.clk_int;
          s_next.rdata[BOPS_CLK_EN_BIT]  = s_reg.clk_en;
          s_next.rdata[BOPS_EMPTY_BIT]   = !pop_valid;
        end
        OFS_CH_GROUP: s_next.rdata = DATA_W'(s_reg.mask);
        OFS_RATE_DIV: s_next.rdata = DATA_W'(s_reg.div);
        OFS_OUT_DATA: s_next.rdata = '0;
        OFS_STATUS: begin
          s_next.rdata[LVL_W-1:0] = level;
          s_next.rdata[17:16]     = 2'(s_reg.state);
        end
        default: s_next.rresp = RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    s_next.arready = !s_next.rvalid;

    // Internal rate generator runs only while its enable is set
    if (s_reg.rate_en) begin
      if (s_reg.rate_cnt == '0) begin
        rate_tick       = 1'b1;
        s_next.rate_cnt = s_reg.div - 16'h0001;
      end else begin
        s_next.rate_cnt = s_reg.rate_cnt - 16'h0001;
      end
    end else begin
      s_next.rate_cnt = '0;
    end
    s_next.ext_q = ext_out_clk;
    tick = s_reg.clk_en &&
           (s_reg.clk_int ? rate_tick
                          : (ext_out_clk && !s_reg.ext_q));

    // Output sequencing
    unique case (s_reg.state)
      BDOS_IDLE: begin
        if (!s_reg.simul) begin
          // One channel per tick, so each channel sees tick / n_act
          if (tick && pop_valid && s_reg.mask != '0) begin
            ch = s_reg.mask[s_reg.ptr] ? s_reg.ptr
                                       : next_act(s_reg.ptr, s_reg.mask);
            pop_ready      = 1'b1;
            s_next.dac[ch] = code;
            s_next.load[ch] = 1'b1;
            s_next.ptr     = next_act(ch, s_reg.mask);
          end
        end else if (s_reg.mask != '0 &&
                     level >= LVL_W'(n_act)) begin
          s_next.state = BDOS_GATHER;
          s_next.ptr   = next_act(CH_W'(NCH - 1), s_reg.mask);
          s_next.left  = n_act;
        end
      end
      BDOS_GATHER: begin
        // Group is already in the buffer, so each pop finds data
        pop_ready = 1'b1;
        s_next.stage[s_reg.ptr] = code;
        s_next.ptr  = next_act(s_reg.ptr, s_reg.mask);
        s_next.left = s_reg.left - 1'b1;
        if (s_reg.left == CNT_W'(1)) begin
          s_next.state = BDOS_ARMED;
        end
      end
      BDOS_ARMED: begin
        if (tick) begin
          for (int i = 0; i < NCH; i++) begin
            if (s_reg.mask[i]) begin
              s_next.dac[i] = s_reg.stage[i];
            end
          end
          s_next.load  = s_reg.mask;
          s_next.state = BDOS_IDLE;
          s_next.ptr   = next_act(CH_W'(NCH - 1), s_reg.mask);
        end
      end
    endcase

    // Clearing the buffer also abandons a partly gathered group
    if (fifo_clear) begin
      pop_ready    = 1'b0;
      s_next.state = BDOS_IDLE;
      s_next.ptr   = next_act(CH_W'(NCH - 1), s_reg.mask);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg          <= '0;
      s_reg.mask     <= '1;
      s_reg.twos     <= RST_TWOS;
      s_reg.simul    <= RST_SIMUL;
      s_reg.div      <= DIV_DEFAULT;
      s_reg.rate_en  <= RST_RATE_EN;
      s_reg.clk_int  <= RST_CLK_INT;
      s_reg.clk_en   <= RST_CLK_EN;
      s_reg.state    <= BDOS_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  bdos_fifo #(
    .DW    (VAL_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk        (clk),
    .arst_n     (arst_n),
    .clear      (fifo_clear),
    .push_valid (push_valid),
    .push_ready (push_ready),
    .push_data  (push_data),
    .pop_valid  (pop_valid),
    .pop_ready  (pop_ready),
    .pop_data   (pop_data),
    .level      (level)
  );

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign dac_value     = s_reg.dac;
  assign dac_load      = s_reg.load;

endmodule : bdos_top
